// ---- shared/apci_map.svh ----
`ifndef APCI_MAP_SVH
`define APCI_MAP_SVH
`define APCI_RESULT_WIDTH      14
`define APCI_EXT_CONV_CYCLES   17
`define APCI_INT_CLK_NS        100
`define APCI_SYS_CLK_NS        25
`define APCI_INT_DIV           (`APCI_INT_CLK_NS / `APCI_SYS_CLK_NS)
`define APCI_INT_CONV_CYCLES   17
`define APCI_RESULT_RESET      14'h0000
`endif

// ---- shared/apci_pkg.sv ----
`include "apci_map.svh"
package apci_pkg;
   typedef enum logic [3:0] {
      APCI_IDLE   = 4'b0001,
      APCI_CONV   = 4'b0010,
      APCI_DONE   = 4'b0100,
      APCI_WAIT   = 4'b1000
   } apci_state_type;
   typedef struct packed {
      logic [`APCI_RESULT_WIDTH-1:0] data;
      logic [`APCI_RESULT_WIDTH-1:0] data_oe_n;
   } apci_bus_type;
endpackage

// ---- hdl/apci_core.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// R1: Result bus is 14 bits, floated unless read strobe and chip select are low.
// R2: Read strobe low with chip select low drives the result on all bits.
// R3: Chip select high makes the interface ignored and the bus floated.
// R4: Conversion-done pulses low when a conversion completes.
// R5: Conversion-done returns high after exactly one conversion clock period.
// R6: Last-done goes low at conversion end, stays low until start falls.
// R7: Last-done asserts in the same cycle as conversion-done.
// R8: Rising start edge enters hold and begins the conversion.
// R9: Sample captured at the start rise; input tracked while start is low.
// R10: External conversion clock must not exceed 15 MHz.
// R11: Clock-source select low uses the external clock input.
// R12: Power-down high halts conversions; low means normal operation.
// R13: The unused tie-low input has no effect.
// R14: External mode result readable at the 17th external clock rise.
// R15: Host keeps start high until the final result has been read.
// R16: Host leaves 50 ns between read strobe rise and start fall.
// R17: Host gives 20 clocks with start high after leaving power-down.
// R18: The last result stays on the output register until a new one completes.
`include "apci_map.svh"
module apci_core
   import apci_pkg::*;
#(
   parameter int WIDTH = `APCI_RESULT_WIDTH
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             conversion_start,
   input  wire logic             chip_select_n,
   input  wire logic             read_n,
   input  wire logic             ext_clock,
   input  wire logic             clock_source_select,
   input  wire logic             power_down_in,
   input  wire logic             unused_tie_low_input,
   input  wire logic [WIDTH-1:0] analog_sample,
   output logic      [WIDTH-1:0] result_bus,
   output logic      [WIDTH-1:0] result_bus_oe_n,
   output logic                  conversion_done_n,
   output logic                  last_conversion_done_n,
   output logic                  track_hold
);
   // Every pin except reset, the tie-low input and analog_sample passes two flip-flops before logic reads it.
   logic [1:0] s_start, s_cs_n, s_rd_n, s_eclk, s_sel, s_pd;
   logic       start_d, eclk_d;
   logic [1:0] next_s_start, next_s_cs_n, next_s_rd_n, next_s_eclk, next_s_sel, next_s_pd;
   logic       next_start_d, next_eclk_d;
   apci_state_type state, next_state;
   logic [4:0]       count, next_count;
   logic [1:0]       div, next_div;
   logic [WIDTH-1:0] sample, next_sample;
   logic [WIDTH-1:0] result, next_result;
   logic             next_done_n, next_last_n, next_hold;
   logic [WIDTH-1:0] next_bus, next_oe_n;
   logic             start_rise, start_fall, conv_tick, read_on;

   // Edges are taken only from the second synchroniser stage, never from the first.
   function automatic logic edge_up(input logic now_level, input logic last_level);
      return now_level & ~last_level;
   endfunction

   function automatic logic edge_down(input logic now_level, input logic last_level);
      return ~now_level & last_level;
   endfunction

   always_comb begin
      next_s_start = {s_start[0], conversion_start};
      next_s_cs_n  = {s_cs_n[0], chip_select_n};
      next_s_rd_n  = {s_rd_n[0], read_n};
      next_s_eclk  = {s_eclk[0], ext_clock};
      next_s_sel   = {s_sel[0], clock_source_select};
      next_s_pd    = {s_pd[0], power_down_in};
      next_start_d = s_start[1];
      next_eclk_d  = s_eclk[1];
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_start <= 2'h0;
         s_cs_n  <= 2'h3;
         s_rd_n  <= 2'h3;
         s_eclk  <= 2'h0;
         s_sel   <= 2'h3;
         s_pd    <= 2'h0;
         start_d <= 1'b0;
         eclk_d  <= 1'b0;
      end else begin
         s_start <= next_s_start;
         s_cs_n  <= next_s_cs_n;
         s_rd_n  <= next_s_rd_n;
         s_eclk  <= next_s_eclk;
         s_sel   <= next_s_sel;
         s_pd    <= next_s_pd;
         start_d <= next_start_d;
         eclk_d  <= next_eclk_d;
      end
   end

   // The internal conversion clock is the system clock divided down; the
   // external one is counted on its sampled rising edges, which limits it
   // to under 20 MHz, half the 40 MHz system rate, which leaves room for 15 MHz.
   always_comb begin
      start_rise = edge_up(s_start[1], start_d); // R8
      start_fall = edge_down(s_start[1], start_d);
      read_on    = ~s_rd_n[1] & ~s_cs_n[1]; // R1 R2 R3
      next_div   = div + 2'h1;
      if (s_sel[1]) begin
         conv_tick = (div == 2'(`APCI_INT_DIV - 1));
      end else begin
         conv_tick = edge_up(s_eclk[1], eclk_d); // R11 R10
      end
   end

   always_comb begin
      next_state  = state;
      next_count  = count;
      next_sample = sample;
      next_result = result;
      next_done_n = 1'b1;
      next_last_n = last_conversion_done_n;
      next_hold   = track_hold;
      if (start_fall) begin
         next_last_n = 1'b1; // R6
      end
      case (state)
         APCI_IDLE: begin
            next_hold = 1'b0; // R9
            if (start_rise) begin
               next_sample = analog_sample; // R9
               next_hold   = 1'b1; // R8
               next_count  = 5'h0;
               next_state  = APCI_CONV;
            end
         end
         APCI_CONV: begin
            if (conv_tick) begin
               next_count = count + 5'h1;
               if (count == 5'(`APCI_EXT_CONV_CYCLES - 1)) begin // R14
                  next_result = sample; // R18
                  next_done_n = 1'b0; // R4
                  next_last_n = 1'b0; // R6 R7
                  next_state  = APCI_DONE;
               end
            end
         end
         APCI_DONE: begin
            // Done stays low until the next conversion clock tick.
            next_done_n = 1'b0;
            if (conv_tick) begin
               next_done_n = 1'b1; // R5
               next_state  = APCI_WAIT;
            end
         end
         APCI_WAIT: begin
            if (~s_start[1]) begin
               next_hold  = 1'b0;
               next_state = APCI_IDLE;
            end
         end
         default: next_state = APCI_IDLE;
      endcase
      if (s_pd[1]) begin // R12
         next_state  = APCI_IDLE;
         next_done_n = 1'b1;
         next_hold   = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state                  <= APCI_IDLE;
         count                  <= 5'h0;
         div                    <= 2'h0;
         sample                 <= '0;
         result                 <= `APCI_RESULT_RESET;
         conversion_done_n      <= 1'b1;
         last_conversion_done_n <= 1'b1;
         track_hold             <= 1'b0;
      end else begin
         state                  <= next_state;
         count                  <= next_count;
         div                    <= next_div;
         sample                 <= next_sample;
         result                 <= next_result;
         conversion_done_n      <= next_done_n;
         last_conversion_done_n <= next_last_n;
         track_hold             <= next_hold;
      end
   end

   // The bus and its enables are registered, so a read shows three clocks after the
   // strobe falls; the delay buys glitch-free enables on every pin.
   always_comb begin
      next_oe_n = read_on ? '0 : '1; // R1 R3
      next_bus  = result; // R2
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         result_bus      <= '0;
         result_bus_oe_n <= '1;
      end else begin
         result_bus      <= next_bus;
         result_bus_oe_n <= next_oe_n;
      end
   end

   // The tie-low input is deliberately left unread.
   logic unused_ok;
   assign unused_ok = unused_tie_low_input; // R13

   chk_float_when_idle: assert property (@(posedge clk) disable iff (reset) // R1
      !$past(read_on) |-> result_bus_oe_n == '1)
      else $error("bus driven without read");

   chk_drive_on_read: assert property (@(posedge clk) disable iff (reset) // R2
      $past(read_on) |-> result_bus_oe_n == '0)
      else $error("bus not driven on read");

   chk_bus_value: assert property (@(posedge clk) disable iff (reset) // R2
      $past(read_on) |-> result_bus == $past(result))
      else $error("bus value differs from result");

   chk_cs_float: assert property (@(posedge clk) disable iff (reset) // R3
      $past(s_cs_n[1]) |-> result_bus_oe_n == '1)
      else $error("bus driven with cs high");

   chk_done_from_conv: assert property (@(posedge clk) disable iff (reset) // R4
      $fell(conversion_done_n) |-> $past(state) == APCI_CONV)
      else $error("done without conv");

   chk_done_width: assert property (@(posedge clk) disable iff (reset || s_pd[1]) // R5
      $fell(conversion_done_n) && s_sel[1]
      |-> !conversion_done_n [*4] ##1 conversion_done_n)
      else $error("done width wrong");

   chk_done_one_tick: assert property (@(posedge clk) disable iff (reset) // R5
      state == APCI_DONE && conv_tick && !s_pd[1] |=> conversion_done_n)
      else $error("done not released on tick");

   chk_last_release: assert property (@(posedge clk) disable iff (reset) // R6
      $rose(last_conversion_done_n) |-> $past(start_fall))
      else $error("last-done released early");

   chk_last_holds_low: assert property (@(posedge clk) disable iff (reset) // R6
      !last_conversion_done_n && s_start[1] |=> !last_conversion_done_n)
      else $error("last-done released while start high");

   chk_done_pairs: assert property (@(posedge clk) disable iff (reset) // R7
      $fell(conversion_done_n) |-> $fell(last_conversion_done_n))
      else $error("done mismatch");

   chk_hold_on_rise: assert property (@(posedge clk) disable iff (reset) // R8
      start_rise && state == APCI_IDLE && !s_pd[1] |=> track_hold)
      else $error("no hold");

   chk_wait_to_idle: assert property (@(posedge clk) disable iff (reset) // R8
      state == APCI_WAIT && !s_start[1] |=> state == APCI_IDLE)
      else $error("no return to idle");

   chk_sample_capture: assert property (@(posedge clk) disable iff (reset) // R9
      start_rise && state == APCI_IDLE |=> sample == $past(analog_sample))
      else $error("sample not captured");

   chk_sample_frozen: assert property (@(posedge clk) disable iff (reset) // R9
      state == APCI_CONV |=> $stable(sample))
      else $error("sample moved in hold");

   chk_track_while_idle: assert property (@(posedge clk) disable iff (reset) // R9
      state == APCI_IDLE && !start_rise |=> !track_hold)
      else $error("hold while tracking");

   chk_ext_tick_only: assert property (@(posedge clk) disable iff (reset) // R11
      !s_sel[1] && state == APCI_CONV && !(s_eclk[1] && !eclk_d) |=> $stable(count))
      else $error("count moved without external edge");

   chk_int_tick_only: assert property (@(posedge clk) disable iff (reset) // R11
      s_sel[1] && state == APCI_CONV && div != 2'(`APCI_INT_DIV - 1) |=> $stable(count))
      else $error("count moved without internal tick");

   chk_pd_halts: assert property (@(posedge clk) disable iff (reset) // R12
      s_pd[1] |=> state == APCI_IDLE)
      else $error("not halted");

   chk_pd_no_done: assert property (@(posedge clk) disable iff (reset) // R12
      s_pd[1] |=> conversion_done_n)
      else $error("done in shutdown");

   chk_pd_no_hold: assert property (@(posedge clk) disable iff (reset) // R12
      s_pd[1] |=> !track_hold)
      else $error("hold in shutdown");

   chk_latency_end: assert property (@(posedge clk) disable iff (reset) // R14
      state == APCI_CONV && conv_tick && count == 5'(`APCI_EXT_CONV_CYCLES - 1) && !s_pd[1] |=> !conversion_done_n)
      else $error("done missing after last tick");

   chk_result_stable: assert property (@(posedge clk) disable iff (reset) // R18
      $changed(result) |-> $fell(conversion_done_n))
      else $error("result changed");

   cov_conv: cover property (@(posedge clk) $fell(conversion_done_n));
   cov_read: cover property (@(posedge clk) result_bus_oe_n == '0);
   cov_ext: cover property (@(posedge clk) !s_sel[1] && $fell(conversion_done_n));
   cov_last_release: cover property (@(posedge clk) $rose(last_conversion_done_n));
   cov_shutdown: cover property (@(posedge clk) $rose(s_pd[1]));
endmodule // apci_core

// ---- tb/apci_ext_clock_model.sv ----
`timescale 1ns/1ps
module apci_ext_clock_model #(
   parameter real HALF_NS = 50.0
) (
   input  wire logic run,
   output logic      ext_clock
);
   // A 10 MHz clock stays under the 15 MHz ceiling and inside what the core can sample.
   initial ext_clock = 1'b0;
   always begin
      #(HALF_NS);
      ext_clock = run ? ~ext_clock : 1'b0;
   end
endmodule // apci_ext_clock_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`include "apci_map.svh"
module tb
   import apci_pkg::*;
;
   localparam int W = `APCI_RESULT_WIDTH;
   logic         clk = 0, reset = 1, cstart = 0, cs_n = 1, rd_n = 1, sel = 1, pd = 0, run = 0, ext_clock;
   logic [W-1:0] smp = '0, bus, oe_n, val, oe;
   logic         done_n, last_n, hold;
   int           miscompares = 0, n_checks = 0, cyc;
   always #12.5 clk = ~clk;
   apci_ext_clock_model xclk_u (.run(run), .ext_clock(ext_clock));
   apci_core dut_u (.clk(clk), .reset(reset), .conversion_start(cstart), .chip_select_n(cs_n), .read_n(rd_n),
      .ext_clock(ext_clock), .clock_source_select(sel), .power_down_in(pd), .unused_tie_low_input(1'b0),
      .analog_sample(smp), .result_bus(bus), .result_bus_oe_n(oe_n), .conversion_done_n(done_n),
      .last_conversion_done_n(last_n), .track_hold(hold));
   task automatic tick(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic chk1(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chkw(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run;
      if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Start is held high from here until the result is read, and the sample moves once hold is on.
   task automatic launch(input logic [W-1:0] v, input int bound);
      smp = v;
      cstart = 0;
      tick(8);
      cstart = 1;
      cyc = 0;
      while (done_n !== 1'b0 && cyc < bound) begin
         tick(1);
         cyc++;
         if (cyc == 6) smp = ~v;
      end
   endtask
   task automatic rd(input logic cs);
      cs_n = cs;
      rd_n = 0;
      tick(4);
      val = bus;
      oe = oe_n;
      rd_n = 1;
      cs_n = 1;
      tick(4);
      chkw("oe_n released", '1, oe_n);
   endtask
   initial begin
      tick(20);
      reset = 0;
      tick(2);
      chkw("oe_n after reset", '1, oe_n);
      chk1("last_n after reset", 1'b1, last_n);
      for (int i = 0; i < 2; i++) begin
         sel = (i == 0);
         run = (i == 1);
         launch(i ? 14'h0001 : 14'h3fff, 200);
         if (cyc >= 200) begin
            miscompares++;
            complete_run();
         end
         chk1("latency", 1'b1, cyc >= 68 && cyc <= 80);
         chk1("track_hold", 1'b1, hold);
         chk1("last_n with done", 1'b0, last_n);
         tick(3);
         chk1("done_n pulse", 1'b0, done_n);
         tick(1);
         chk1("done_n end", 1'b1, done_n);
         rd(0);
         chkw("oe_n read", '0, oe);
         chkw("result", i ? 14'h0001 : 14'h3fff, val);
         rd(0);
         chkw("result again", i ? 14'h0001 : 14'h3fff, val);
         rd(1);
         chkw("oe_n deselected", '1, oe);
         chk1("last_n held", 1'b0, last_n);
         cstart = 0;
         tick(6);
         chk1("last_n after start fall", 1'b1, last_n);
      end
      pd = 1;
      launch(14'h1555, 150);
      chk1("done_n in shutdown", 1'b1, done_n);
      chk1("hold in shutdown", 1'b0, hold);
      pd = 0;
      tick(80);
      launch(14'h2aaa, 200);
      if (cyc >= 200) begin
         miscompares++;
         complete_run();
      end
      chk1("done_n after wake", 1'b0, done_n);
      rd(0);
      chkw("result after wake", 14'h2aaa, val);
      complete_run();
   end
endmodule // tb
